// File: scoc_pkg.sv
// Package of constants and types for the system clock and oscillator control block
package scoc_pkg;

  // ----------------------------------------------------------------
  // Bus and register layout
  // ----------------------------------------------------------------
  localparam int unsigned BUS_W  = 32;
  localparam int unsigned REG_W  = 16;
  localparam int unsigned TRIM_W = 8;

  // Register index; the byte address is four times the index
  localparam logic [31:0] IDX_SYS_CTRL  = 32'h5000_0012;
  localparam logic [31:0] IDX_SYS_STAT  = 32'h5000_0014;
  localparam logic [31:0] IDX_TRIM_TIME = 32'h5000_0016;
  localparam logic [31:0] IDX_SLOW_OSC  = 32'h5000_0020;
  localparam logic [31:0] IDX_FAST_OSC  = 32'h5000_0022;
  localparam logic [31:0] IDX_EXTRA_RC  = 32'h5000_0024;
  // Address bits [DEC_W+1:2] are compared against the low index bits
  localparam int unsigned DEC_W = 16;

  // Reset values of the stored registers
  localparam logic [15:0] RST_SYS_CTRL  = 16'h0000;
  localparam logic [15:0] RST_TRIM_TIME = 16'h00a2;
  localparam logic [15:0] RST_SLOW_OSC  = 16'h079c;
  localparam logic [15:0] RST_FAST_OSC  = 16'h00a0;
  localparam logic [15:0] RST_EXTRA_RC  = 16'h0170;
  localparam logic [5:0]  RST_DOMAINS   = 6'h15;

  // Writable bits; all others are reserved and read as zero
  localparam logic [15:0] WM_SYS_CTRL  = 16'h0017;
  localparam logic [15:0] WM_TRIM_TIME = 16'h00ff;
  localparam logic [15:0] WM_SLOW_OSC  = 16'h1fff;
  localparam logic [15:0] WM_FAST_OSC  = 16'h03ff;
  localparam logic [15:0] WM_EXTRA_RC  = 16'h1ff0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_REMAP_LSB    = 0;
  localparam int unsigned F_KEEP_RAM     = 2;
  localparam int unsigned F_COPY_EN      = 4;
  localparam int unsigned F_TRIM_LSB     = 4;
  localparam int unsigned F_SETTLE_LSB   = 0;
  localparam int unsigned F_AMP_OFF      = 12;
  localparam int unsigned F_SRC_TRIM_LSB = 8;
  localparam int unsigned F_SRC_ON       = 7;
  localparam int unsigned F_SXT_CUR_LSB  = 3;
  localparam int unsigned F_SXT_RES_LSB  = 1;
  localparam int unsigned F_SXT_ON       = 0;
  localparam int unsigned F_NOISE_ON     = 9;
  localparam int unsigned F_BIAS_HOLD    = 8;
  localparam int unsigned F_FXT_CUR_LSB  = 5;
  localparam int unsigned F_FRC_TRIM_LSB = 1;
  localparam int unsigned F_FRC_ON       = 0;
  localparam int unsigned F_XRC_PICK     = 12;
  localparam int unsigned F_XRC_ON       = 11;
  localparam int unsigned F_XRC_LOWF     = 10;
  localparam int unsigned F_XRC_BIAS_LSB = 8;
  localparam int unsigned F_XRC_NTC_LSB  = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned TICK_PERIOD_US = 250;
  localparam logic [11:0] TICK_DIV       = 12'hfa0;

  typedef enum logic [1:0] {
    SCOC_IDLE   = 2'b00,
    SCOC_TRIM   = 2'b01,
    SCOC_SETTLE = 2'b11,
    SCOC_DONE   = 2'b10
  } scoc_seq_t;

endpackage

// File: scoc_top.sv
// System control, status, crystal trim sequencer and oscillator control registers
// Operation
// [RULE1] Two-bit field picks memory at address zero
// [RULE2] Retention bit keeps system domain on, no copy
// [RULE3] Software sets copy bit to emulate startup time
// [RULE4] Settled flag rises only after settle wait
// [RULE5] Trim-ready shows applied trim equals programmed value
// [RULE6] Domain up/down status pairs, reset up0 down1
// [RULE7] Trim delay field in 250 us steps
// [RULE8] Settle delay field in 250 us steps
// [RULE9] Code N waits between N-1 and N ticks
// [RULE10] Tick is fast RC clock divided 4000
// [RULE11] Software sets amp-loop-off only for external clock
// [RULE12] Slow RC four-bit trim, resets to 7
// [RULE13] Slow RC and slow crystal enable bits
// [RULE14] Slow crystal bias current field, resets 3
// [RULE15] Slow crystal bias resistor field, resets 2
// [RULE16] Software toggles bias hold around deep sleep
// [RULE17] Fast crystal bias current field, resets 5
// [RULE18] Fast RC trim and enable, reset 0
// [RULE19] Fast crystal noise filter enable bit 9
// [RULE20] Extra RC enable, source pick, low frequency
// [RULE21] Copy bit copies OTP to RAM on wake
// [RULE22] Reserved bits read zero, status ignores writes
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
module scoc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  input  wire logic [31:0] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // ----------------------------------------------------------------
  // Hardware side
  // ----------------------------------------------------------------
  input  wire logic        fast_rc_pulse_i,
  input  wire logic        fast_crystal_enable_i,
  input  wire logic [7:0]  crystal_adjust_value_i,
  input  wire logic        system_power_domain_wake_i,
  input  wire logic        system_power_domain_sleep_req_i,
  input  wire logic        debug_domain_on_i,
  input  wire logic        debug_domain_off_i,
  input  wire logic        peripheral_domain_on_i,
  input  wire logic        peripheral_domain_off_i,
  input  wire logic        radio_domain_on_i,
  input  wire logic        radio_domain_off_i,
  output logic [1:0]       boot_memory_select_o,
  output logic             dev_keep_system_ram_o,
  output logic             system_power_domain_off_o,
  output logic             ram_copy_start_o,
  output logic [7:0]       fast_crystal_trim_o,
  output logic             fast_crystal_trim_apply_o,
  output logic             fast_crystal_settled_o,
  output logic             fast_crystal_adjust_done_o,
  output logic             slow_crystal_amp_loop_off_o,
  output logic [3:0]       slow_rc_freq_adjust_o,
  output logic             slow_rc_on_o,
  output logic [3:0]       slow_crystal_bias_current_o,
  output logic [1:0]       slow_crystal_bias_resistor_o,
  output logic             slow_crystal_on_o,
  output logic             fast_crystal_noise_filter_on_o,
  output logic             fast_crystal_bias_hold_on_o,
  output logic [2:0]       fast_crystal_bias_current_o,
  output logic [3:0]       fast_rc_freq_adjust_o,
  output logic             fast_rc_on_o,
  output logic             slow_source_pick_extra_rc_o,
  output logic             extra_rc_on_o,
  output logic             extra_rc_very_low_freq_o,
  output logic [1:0]       extra_rc_bias_o,
  output logic [3:0]       extra_rc_temp_adjust_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]       sys_ctrl_q;
  logic [15:0]       trim_time_q;
  logic [15:0]       slow_osc_q;
  logic [15:0]       fast_osc_q;
  logic [15:0]       extra_rc_q;
  logic [5:0]        domains_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic [31:0]       dat_d;
  logic              req;
  logic              wr;
  logic [15:0]       wdat;
  logic [15:0]       bmask;
  logic [15:0]       word_adr;
  logic              hit_sys;
  logic              hit_stat;
  logic              hit_trim;
  logic              hit_slow;
  logic              hit_fast;
  logic              hit_xrc;
  logic [11:0]       div_q;
  logic              tick;
  scoc_pkg::scoc_seq_t state_q;
  logic [3:0]        cnt_q;
  logic              apply_q;
  logic              settled_q;
  logic [7:0]        applied_q;
  logic              adjust_done_q;
  logic              copy_q;
  logic              pd_off_q;
  logic [3:0]        trim_code;
  logic [3:0]        settle_code;
  logic              keep_ram;
  logic              copy_en;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req      = cyc_i & stb_i;
  assign wr       = req & we_i & ack_q;
  assign word_adr = adr_i[scoc_pkg::DEC_W+1:2];
  assign hit_sys  = word_adr == scoc_pkg::IDX_SYS_CTRL[15:0];
  assign hit_stat = word_adr == scoc_pkg::IDX_SYS_STAT[15:0];
  assign hit_trim = word_adr == scoc_pkg::IDX_TRIM_TIME[15:0];
  assign hit_slow = word_adr == scoc_pkg::IDX_SLOW_OSC[15:0];
  assign hit_fast = word_adr == scoc_pkg::IDX_FAST_OSC[15:0];
  assign hit_xrc  = word_adr == scoc_pkg::IDX_EXTRA_RC[15:0];
  assign wdat     = dat_i[15:0];
  assign bmask    = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  // Merge only enabled lanes and writable bits; reserved bits stay zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask);
    merge = (old & ~(bmask & wmask)) | (wdat & bmask & wmask); // RULE22
  endfunction

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    dat_d = 32'h0000_0000;
    unique case (1'b1)
      hit_sys:  dat_d[15:0] = sys_ctrl_q;
      hit_stat: dat_d[15:0] = {8'h00, settled_q, adjust_done_q, domains_q}; // RULE6
      hit_trim: dat_d[15:0] = trim_time_q;
      hit_slow: dat_d[15:0] = slow_osc_q;
      hit_fast: dat_d[15:0] = fast_osc_q;
      hit_xrc:  dat_d[15:0] = extra_rc_q;
      default:  dat_d = 32'h0000_0000;
    endcase
  end

  // Read data sampled at the request edge, presented with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      dat_q <= dat_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Status has no write path, so writes to it are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_ctrl_q  <= scoc_pkg::RST_SYS_CTRL;
      trim_time_q <= scoc_pkg::RST_TRIM_TIME;
      slow_osc_q  <= scoc_pkg::RST_SLOW_OSC;
      fast_osc_q  <= scoc_pkg::RST_FAST_OSC;
      extra_rc_q  <= scoc_pkg::RST_EXTRA_RC;
    end else if (wr) begin
      if (hit_sys) begin
        sys_ctrl_q <= merge(sys_ctrl_q, scoc_pkg::WM_SYS_CTRL); // RULE1
      end
      if (hit_trim) begin
        trim_time_q <= merge(trim_time_q, scoc_pkg::WM_TRIM_TIME); // RULE7
      end
      if (hit_slow) begin
        slow_osc_q <= merge(slow_osc_q, scoc_pkg::WM_SLOW_OSC); // RULE12
      end
      if (hit_fast) begin
        fast_osc_q <= merge(fast_osc_q, scoc_pkg::WM_FAST_OSC); // RULE18
      end
      if (hit_xrc) begin
        extra_rc_q <= merge(extra_rc_q, scoc_pkg::WM_EXTRA_RC); // RULE20
      end
    end
  end

  assign keep_ram    = sys_ctrl_q[scoc_pkg::F_KEEP_RAM];
  assign copy_en     = sys_ctrl_q[scoc_pkg::F_COPY_EN];
  assign trim_code   = trim_time_q[scoc_pkg::F_TRIM_LSB+:4];
  assign settle_code = trim_time_q[scoc_pkg::F_SETTLE_LSB+:4];

  // Field outputs straight from the register flops
  assign boot_memory_select_o           = sys_ctrl_q[scoc_pkg::F_REMAP_LSB+:2]; // RULE1
  assign dev_keep_system_ram_o          = keep_ram;
  assign slow_crystal_amp_loop_off_o    = slow_osc_q[scoc_pkg::F_AMP_OFF];
  assign slow_rc_freq_adjust_o          = slow_osc_q[scoc_pkg::F_SRC_TRIM_LSB+:4]; // RULE12
  assign slow_rc_on_o                   = slow_osc_q[scoc_pkg::F_SRC_ON]; // RULE13
  assign slow_crystal_bias_current_o    = slow_osc_q[scoc_pkg::F_SXT_CUR_LSB+:4]; // RULE14
  assign slow_crystal_bias_resistor_o   = slow_osc_q[scoc_pkg::F_SXT_RES_LSB+:2]; // RULE15
  assign slow_crystal_on_o              = slow_osc_q[scoc_pkg::F_SXT_ON]; // RULE13
  assign fast_crystal_noise_filter_on_o = fast_osc_q[scoc_pkg::F_NOISE_ON]; // RULE19
  assign fast_crystal_bias_hold_on_o    = fast_osc_q[scoc_pkg::F_BIAS_HOLD];
  assign fast_crystal_bias_current_o    = fast_osc_q[scoc_pkg::F_FXT_CUR_LSB+:3]; // RULE17
  assign fast_rc_freq_adjust_o          = fast_osc_q[scoc_pkg::F_FRC_TRIM_LSB+:4]; // RULE18
  assign fast_rc_on_o                   = fast_osc_q[scoc_pkg::F_FRC_ON]; // RULE18
  assign slow_source_pick_extra_rc_o    = extra_rc_q[scoc_pkg::F_XRC_PICK]; // RULE20
  assign extra_rc_on_o                  = extra_rc_q[scoc_pkg::F_XRC_ON]; // RULE20
  assign extra_rc_very_low_freq_o       = extra_rc_q[scoc_pkg::F_XRC_LOWF]; // RULE20
  assign extra_rc_bias_o                = extra_rc_q[scoc_pkg::F_XRC_BIAS_LSB+:2];
  assign extra_rc_temp_adjust_o         = extra_rc_q[scoc_pkg::F_XRC_NTC_LSB+:4];

  // ----------------------------------------------------------------
  // Power domain status and RAM copy
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      domains_q <= scoc_pkg::RST_DOMAINS;
    end else begin
      domains_q <= {debug_domain_on_i, debug_domain_off_i, peripheral_domain_on_i,
                    peripheral_domain_off_i, radio_domain_on_i, radio_domain_off_i}; // RULE6
    end
  end

  // Copy bit alone does nothing while RAM is kept; it only shapes startup time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      copy_q   <= 1'b0;
      pd_off_q <= 1'b0;
    end else begin
      copy_q   <= system_power_domain_wake_i & copy_en & ~keep_ram; // RULE21 RULE2 RULE3
      pd_off_q <= system_power_domain_sleep_req_i & ~keep_ram; // RULE2
    end
  end

  assign ram_copy_start_o          = copy_q;
  assign system_power_domain_off_o = pd_off_q;

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  // Free running, so the first tick after a start is not aligned
  assign tick = fast_rc_pulse_i & (div_q == scoc_pkg::TICK_DIV - 12'h001); // RULE10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 12'h000;
    end else if (fast_rc_pulse_i) begin
      div_q <= tick ? 12'h000 : div_q + 12'h001; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Crystal trim sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= scoc_pkg::SCOC_IDLE;
      cnt_q     <= 4'h0;
      apply_q   <= 1'b0;
      settled_q <= 1'b0;
    end else begin
      apply_q <= 1'b0;
      if (!fast_crystal_enable_i) begin
        state_q   <= scoc_pkg::SCOC_IDLE;
        settled_q <= 1'b0;
      end else begin
        unique case (state_q)
          scoc_pkg::SCOC_IDLE: begin
            cnt_q   <= trim_code; // RULE7
            state_q <= scoc_pkg::SCOC_TRIM;
          end
          scoc_pkg::SCOC_TRIM: begin
            if (cnt_q == 4'h0) begin
              apply_q <= 1'b1; // RULE7
              cnt_q   <= settle_code; // RULE8
              state_q <= scoc_pkg::SCOC_SETTLE;
            end else if (tick) begin
              cnt_q <= cnt_q - 4'h1; // RULE9
            end
          end
          scoc_pkg::SCOC_SETTLE: begin
            if (cnt_q == 4'h0) begin
              settled_q <= 1'b1; // RULE4 RULE8
              state_q   <= scoc_pkg::SCOC_DONE;
            end else if (tick) begin
              cnt_q <= cnt_q - 4'h1; // RULE9
            end
          end
          scoc_pkg::SCOC_DONE: begin
            state_q <= scoc_pkg::SCOC_DONE;
          end
        endcase
      end
    end
  end

  // Applied trim is compared every cycle against the programmed value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied_q     <= 8'h00;
      adjust_done_q <= 1'b1;
    end else begin
      if (apply_q) begin
        applied_q <= crystal_adjust_value_i;
      end
      adjust_done_q <= (applied_q == crystal_adjust_value_i); // RULE5
    end
  end

  assign fast_crystal_trim_o        = applied_q;
  assign fast_crystal_trim_apply_o  = apply_q;
  assign fast_crystal_settled_o     = settled_q;
  assign fast_crystal_adjust_done_o = adjust_done_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_remap_write: assert property ( // RULE1
    (wr && hit_sys && sel_i[0]) |=> (boot_memory_select_o == $past(dat_i[1:0])))
    else $error("remap field did not take written value");

  a_keep_no_copy: assert property ( // RULE2
    (keep_ram && $stable(keep_ram)) |=> (!ram_copy_start_o && !system_power_domain_off_o))
    else $error("system domain off or copy while RAM kept");

  a_copy_on_wake: assert property ( // RULE21
    (system_power_domain_wake_i && copy_en && !keep_ram) |=> ram_copy_start_o)
    else $error("no copy after wake with copy enabled");

  a_settled_cause: assert property ( // RULE4
    $rose(fast_crystal_settled_o) |-> ($past(state_q) == scoc_pkg::SCOC_SETTLE && $past(cnt_q) == 4'h0))
    else $error("settled flag rose outside settle end");

  a_trim_direct: assert property ( // RULE7
    (state_q == scoc_pkg::SCOC_IDLE && fast_crystal_enable_i && trim_code == 4'h0)
      ##1 fast_crystal_enable_i |=> fast_crystal_trim_apply_o)
    else $error("code zero did not apply trim at once");

  a_settle_direct: assert property ( // RULE8
    (fast_crystal_trim_apply_o && settle_code == 4'h0 && fast_crystal_enable_i) ##1 fast_crystal_enable_i
      |=> fast_crystal_settled_o)
    else $error("settle code zero did not set flag at once");

  a_count_hold: assert property ( // RULE9
    (state_q == scoc_pkg::SCOC_TRIM && cnt_q != 4'h0 && !tick && fast_crystal_enable_i) |=> $stable(cnt_q))
    else $error("delay count moved without a tick");

  a_tick_div: assert property ( // RULE10
    tick |=> (div_q == 12'h000) ##1 (div_q <= 12'h001))
    else $error("tick divider did not restart");

  a_trim_ready: assert property ( // RULE5
    (apply_q && $stable(crystal_adjust_value_i)) |=> ##1 fast_crystal_adjust_done_o)
    else $error("trim ready not shown after apply");

  a_status_read: assert property ( // RULE6
    (req && !ack_q && !we_i && hit_stat) |=> (dat_o[7:0] == {$past(fast_crystal_settled_o),
      $past(fast_crystal_adjust_done_o), $past(domains_q)} && dat_o[31:8] == 24'h000000))
    else $error("status read shows wrong bits");

  a_reserved_zero: assert property ( // RULE22
    ack_o |-> (dat_o[31:16] == 16'h0000))
    else $error("reserved read bits not zero");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_osc_reset: assert property ( // RULE12 RULE13 RULE14 RULE15 RULE17 RULE18
    $fell(rst_i) |-> (slow_rc_freq_adjust_o == 4'h7 && slow_rc_on_o && slow_crystal_bias_current_o == 4'h3
      && slow_crystal_bias_resistor_o == 2'h2 && fast_crystal_bias_current_o == 3'h5 && !fast_rc_on_o))
    else $error("oscillator fields wrong after reset");

  c_full_sequence: cover property (
    fast_crystal_trim_apply_o ##[1:16] $rose(fast_crystal_settled_o));
  c_copy_start: cover property (ram_copy_start_o);
  c_unmapped_read: cover property (req && !ack_q && !(hit_sys | hit_stat | hit_trim | hit_slow | hit_fast | hit_xrc));
  c_keep_sleep: cover property (keep_ram && system_power_domain_sleep_req_i);

endmodule

// File: scoc_top_test.sv
// Self-checking bench for the system clock and oscillator control block
`timescale 1ns/10ps
module scoc_top_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic [31:0] adr_i  = 32'h0;
  logic [31:0] dat_i  = 32'h0;
  logic [3:0]  sel_i  = 4'h0;
  logic        we_i   = 1'b0;
  logic        cyc_i  = 1'b0;
  logic        stb_i  = 1'b0;
  logic        pulse  = 1'b1;
  logic        fce    = 1'b0;
  logic [7:0]  adj    = 8'h0;
  logic        wake   = 1'b0;
  logic        sleep  = 1'b0;
  logic [5:0]  dom    = 6'h15;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [1:0]  boot_sel;
  logic        keep, pd_off, copy, apply, settled, adone;
  logic [7:0]  trim_o;
  wire  [12:0] slow_f;
  wire  [9:0]  fast_f;
  wire  [12:4] xrc_f;
  logic [31:0] r;
  int          n_fail     = 0;
  int          n_compared = 0;
  // Register byte addresses, reset values and values after an all-ones write
  localparam logic [31:0] A[6]  = '{32'h48, 32'h50, 32'h58, 32'h80, 32'h88, 32'h90};
  localparam logic [31:0] RV[6] = '{32'h0, 32'h55, 32'ha2, 32'h79c, 32'ha0, 32'h170};
  localparam logic [31:0] AO[6] = '{32'h17, 32'h55, 32'hff, 32'h1fff, 32'h3ff, 32'h1ff0};

  scoc_top i_dut (
    .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
    .fast_rc_pulse_i(pulse), .fast_crystal_enable_i(fce), .crystal_adjust_value_i(adj),
    .system_power_domain_wake_i(wake), .system_power_domain_sleep_req_i(sleep),
    .debug_domain_on_i(dom[5]), .debug_domain_off_i(dom[4]), .peripheral_domain_on_i(dom[3]),
    .peripheral_domain_off_i(dom[2]), .radio_domain_on_i(dom[1]), .radio_domain_off_i(dom[0]),
    .boot_memory_select_o(boot_sel), .dev_keep_system_ram_o(keep), .system_power_domain_off_o(pd_off),
    .ram_copy_start_o(copy), .fast_crystal_trim_o(trim_o), .fast_crystal_trim_apply_o(apply),
    .fast_crystal_settled_o(settled), .fast_crystal_adjust_done_o(adone),
    .slow_crystal_amp_loop_off_o(slow_f[12]), .slow_rc_freq_adjust_o(slow_f[11:8]), .slow_rc_on_o(slow_f[7]),
    .slow_crystal_bias_current_o(slow_f[6:3]), .slow_crystal_bias_resistor_o(slow_f[2:1]),
    .slow_crystal_on_o(slow_f[0]), .fast_crystal_noise_filter_on_o(fast_f[9]),
    .fast_crystal_bias_hold_on_o(fast_f[8]), .fast_crystal_bias_current_o(fast_f[7:5]),
    .fast_rc_freq_adjust_o(fast_f[4:1]), .fast_rc_on_o(fast_f[0]), .slow_source_pick_extra_rc_o(xrc_f[12]),
    .extra_rc_on_o(xrc_f[11]), .extra_rc_very_low_freq_o(xrc_f[10]), .extra_rc_bias_o(xrc_f[9:8]),
    .extra_rc_temp_adjust_o(xrc_f[7:4])
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Classic cycle; ack is sampled at the edge, so no wait count is assumed
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    chk("bus ack", 32'h1, 32'(ack_o));
    r = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  task automatic wake_chk(input logic e);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    @(posedge clk_i);
    chk("copy start", 32'(e), 32'(copy));
    @(posedge clk_i);
    chk("copy pulse end", 32'h0, 32'(copy));
  endtask

  // Tick is 4000 pulses and pulses come every cycle, so code N waits N-1..N times 4000 cycles
  task automatic seq(input int tc, input int sc, input logic [7:0] v);
    int n;
    bus(1'b1, A[2], 32'(tc * 16 + sc), 4'h1);
    adj <= v; fce <= 1'b1; n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (apply !== 1'b1 && n < 9000);
    chk("trim wait in range", 32'h1, 32'(n >= (tc - 1) * 4000 && n <= tc * 4000 + 4));
    chk("settled before apply", 32'h0, 32'(settled));
    chk("ready before apply", 32'h0, 32'(adone));
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (settled !== 1'b1 && n < 9000);
    chk("settle wait in range", 32'h1, 32'(n >= (sc - 1) * 4000 && n <= sc * 4000 + 4));
    chk("applied trim", 32'(v), 32'(trim_o));
    // Ready is the registered compare, one cycle behind the applied trim
    @(posedge clk_i);
    chk("ready after apply", 32'h1, 32'(adone));
    fce <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("settled cleared", 32'h0, 32'(settled));
  endtask

  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, A[i], 32'h0, 4'h3);
      chk("reset value", RV[i], r);
    end
    chk("slow fields", 32'h79c, 32'(slow_f));
    chk("fast fields", 32'ha0, 32'(fast_f));
    chk("rcx fields", 32'h17, 32'(xrc_f));
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, A[i], 32'hffff_ffff, 4'hf);
      bus(1'b0, A[i], 32'h0, 4'hf);
      chk("all ones readback", AO[i], r);
    end
    bus(1'b1, 32'h44, 32'hffff_ffff, 4'hf);
    bus(1'b0, 32'h44, 32'h0, 4'hf);
    chk("unmapped read", 32'h0, r);
    chk("slow fields set", 32'h1fff, 32'(slow_f));
    chk("fast fields set", 32'h3ff, 32'(fast_f));
    chk("rcx fields set", 32'h1ff, 32'(xrc_f));
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, A[0], 32'(m), 4'h1);
      @(posedge clk_i);
      chk("boot select", 32'(m), 32'(boot_sel));
    end
    sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("keep and off", 32'h1, 32'({keep, pd_off}));
    bus(1'b1, A[0], 32'h14, 4'h1);
    repeat (2) @(posedge clk_i);
    chk("keep and off", 32'h2, 32'({keep, pd_off}));
    wake_chk(1'b0);
    bus(1'b1, A[0], 32'h10, 4'h1);
    wake_chk(1'b1);
    sleep <= 1'b0; dom <= 6'h2a;
    repeat (2) @(posedge clk_i);
    bus(1'b0, A[1], 32'h0, 4'h3);
    chk("domain status", 32'h6a, r);
    seq(0, 0, 8'h5a);
    seq(2, 1, 8'ha5);
    give_verdict();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule
